/* File: pmm_program_memory_mapper.sv */
`timescale 1ns/10ps
// How it works
// R1: three 24-bit spaces of 16M words mixing internal and external memory
// R2: default program RAM is 80 banks of 256 words from address zero
// R3: memory switch is operating-mode register bit 7
// R4: memory switch set moves 8 X and 8 Y banks into program RAM
// R5: cache enable turns 4 program banks into cache, addresses go external
// R6: switch clear gives 20K internal, external from 5000, 19K with cache
// R7: switch set gives 24K internal, external from 6000, 23K with cache
// R8: cached 1K range not directly reachable, goes to external memory
// R9: FF0000 to FF00BF decode to 192-word bootstrap ROM
// R10: software avoids reserved FF00C0 to FFFFFF
// R11: software sets cache enable before loading program RAM
// R12: external reach 64K in 16-bit, 256K with 18 lines, 4M with attributes
// R13: cache sits at 4C00-4FFF or 5C00-5FFF, routed external
// R14: software clears cache enable before changing the memory switch
// R15: sixteen-bit compat mode limits addresses to FFFF, 16-bit words
// R16: anything not internal, bootstrap or reserved goes external
module pmm_program_memory_mapper
  import pmm_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [23:0] operating_mode_register_i,
  input wire logic [23:0] status_register_i,
  input wire logic req_i,
  input wire logic [ADDR_W-1:0] addr_i,
  output logic sel_pram_o,
  output logic sel_boot_o,
  output logic sel_rsvd_o,
  output logic sel_ext_o,
  output logic [14:0] pram_addr_o,
  output logic [7:0] boot_addr_o,
  output logic [EXT_ADDR_W+ATTR_W-1:0] ext_addr_o,
  output logic [ADDR_W-1:0] pram_words_o,
  output logic [ADDR_W-1:0] ext_base_o,
  output logic cache_active_o,
  output logic wide_words_o
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  logic [1:0] rst_sync_q;
  logic rst_n;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'h1};
    end
  end
  assign rst_n = rst_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // mode bits
  logic memory_switch;
  logic cache_en;
  logic sixteen_bit_compat;
  assign memory_switch = operating_mode_register_i[OMR_MS_BIT]; // R3
  assign cache_en = status_register_i[SR_CE_BIT];
  assign sixteen_bit_compat = status_register_i[SR_SC_BIT];

  // map limits for the present mode
  logic [23:0] pram_top;
  logic [23:0] cache_lo;
  logic [23:0] int_top;
  always_comb begin
    pram_top = memory_switch ? PRAM_TOP_MS1 : PRAM_TOP_MS0; // R4 R6 R7
    cache_lo = memory_switch ? CACHE_LO_MS1 : CACHE_LO_MS0; // R13
    int_top = cache_en ? cache_lo : pram_top; // R5 R8
  end

  ////////////////////////////////////////////////////////////////////////////
  // target decode
  function automatic pmm_tgt_e decode(input logic [23:0] a, input logic [23:0] top,
                                      input logic sc);
    logic [23:0] ea;
    ea = sc ? (a & SC_LIMIT) : a; // R15
    if (ea < top) begin
      decode = PMM_TGT_PRAM; // R2
    end else if (ea >= BOOT_LO && ea <= BOOT_HI) begin
      decode = PMM_TGT_BOOT; // R9
    end else if (ea >= RSVD_LO && ea <= RSVD_HI) begin
      decode = PMM_TGT_RSVD; // R10
    end else begin
      decode = PMM_TGT_EXT; // R16
    end
  endfunction

  logic [23:0] eff_addr;
  pmm_tgt_e tgt;
  always_comb begin
    eff_addr = sixteen_bit_compat ? (addr_i & SC_LIMIT) : addr_i; // R15
    tgt = req_i ? decode(addr_i, int_top, sixteen_bit_compat) : PMM_TGT_NONE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered selects and addresses
  logic sel_pram_q, sel_pram_d, sel_boot_q, sel_boot_d;
  logic sel_rsvd_q, sel_rsvd_d, sel_ext_q, sel_ext_d;
  logic [14:0] pram_addr_q, pram_addr_d;
  logic [7:0] boot_addr_q, boot_addr_d;
  logic [EXT_ADDR_W+ATTR_W-1:0] ext_addr_q, ext_addr_d;
  logic [23:0] pram_words_q, pram_words_d, ext_base_q, ext_base_d;
  logic cache_q, cache_d, wide_q, wide_d;
  always_comb begin
    sel_pram_d = (tgt == PMM_TGT_PRAM);
    sel_boot_d = (tgt == PMM_TGT_BOOT);
    sel_rsvd_d = (tgt == PMM_TGT_RSVD);
    sel_ext_d = (tgt == PMM_TGT_EXT); // R8 R13
    pram_addr_d = eff_addr[14:0];
    boot_addr_d = eff_addr[7:0];
    ext_addr_d = eff_addr[EXT_ADDR_W+ATTR_W-1:0]; // R12
    if (sixteen_bit_compat) begin
      ext_addr_d[EXT_ADDR_W+ATTR_W-1:NARROW_W] = '0; // R12 R15
    end
    pram_words_d = int_top; // R6 R7
    ext_base_d = pram_top; // R6 R7
    cache_d = cache_en; // R5
    wide_d = !sixteen_bit_compat; // R1 R15
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sel_pram_q <= 1'h0;
      sel_boot_q <= 1'h0;
      sel_rsvd_q <= 1'h0;
      sel_ext_q <= 1'h0;
      pram_addr_q <= 15'h0;
      boot_addr_q <= 8'h0;
      ext_addr_q <= '0;
      pram_words_q <= PRAM_TOP_MS0;
      ext_base_q <= PRAM_TOP_MS0;
      cache_q <= 1'h0;
      wide_q <= 1'h1;
    end else begin
      sel_pram_q <= sel_pram_d;
      sel_boot_q <= sel_boot_d;
      sel_rsvd_q <= sel_rsvd_d;
      sel_ext_q <= sel_ext_d;
      pram_addr_q <= pram_addr_d;
      boot_addr_q <= boot_addr_d;
      ext_addr_q <= ext_addr_d;
      pram_words_q <= pram_words_d;
      ext_base_q <= ext_base_d;
      cache_q <= cache_d;
      wide_q <= wide_d;
    end
  end

  assign sel_pram_o = sel_pram_q;
  assign sel_boot_o = sel_boot_q;
  assign sel_rsvd_o = sel_rsvd_q;
  assign sel_ext_o = sel_ext_q;
  assign pram_addr_o = pram_addr_q;
  assign boot_addr_o = boot_addr_q;
  assign ext_addr_o = ext_addr_q;
  assign pram_words_o = pram_words_q;
  assign ext_base_o = ext_base_q;
  assign cache_active_o = cache_q;
  assign wide_words_o = wide_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_pram_range;
    @(posedge clk_i) disable iff (!rst_n)
    (req_i && !sixteen_bit_compat && addr_i < int_top) |=> sel_pram_o;
  endproperty
  a_pram_range: assert property (p_pram_range) else $error("pram miss"); // R2

  property p_ms_bank;
    @(posedge clk_i) disable iff (!rst_n)
    (req_i && !sixteen_bit_compat && !cache_en && memory_switch
     && addr_i >= PRAM_TOP_MS0 && addr_i < PRAM_TOP_MS1) |=> sel_pram_o;
  endproperty
  a_ms_bank: assert property (p_ms_bank) else $error("switched banks not internal"); // R4

  property p_cache_ext;
    @(posedge clk_i) disable iff (!rst_n)
    (req_i && !sixteen_bit_compat && cache_en && addr_i >= cache_lo && addr_i < pram_top)
      |=> (sel_ext_o && !sel_pram_o);
  endproperty
  a_cache_ext: assert property (p_cache_ext) else $error("cache range not external"); // R8

  property p_ext_base;
    @(posedge clk_i) disable iff (!rst_n)
    (req_i && !sixteen_bit_compat && addr_i == pram_top) |=> sel_ext_o;
  endproperty
  a_ext_base: assert property (p_ext_base) else $error("external base wrong"); // R6

  // switched map: 24K internal, or 23K with cache, external from 6000
  property p_size;
    @(posedge clk_i) disable iff (!rst_n)
    memory_switch |=> (ext_base_o == PRAM_TOP_MS1
      && pram_words_o == ($past(cache_en) ? CACHE_LO_MS1 : PRAM_TOP_MS1));
  endproperty
  a_size: assert property (p_size) else $error("program size wrong"); // R7

  property p_boot;
    @(posedge clk_i) disable iff (!rst_n)
    (req_i && !sixteen_bit_compat && addr_i >= BOOT_LO && addr_i <= BOOT_HI)
      |=> (sel_boot_o && boot_addr_o < BOOT_WORDS);
  endproperty
  a_boot: assert property (p_boot) else $error("boot decode wrong"); // R9

  property p_onehot;
    @(posedge clk_i) disable iff (!rst_n)
    $onehot0({sel_pram_o, sel_boot_o, sel_rsvd_o, sel_ext_o});
  endproperty
  a_onehot: assert property (p_onehot) else $error("multiple selects"); // R16

  property p_sc_limit;
    @(posedge clk_i) disable iff (!rst_n)
    (req_i && sixteen_bit_compat) |=> (!sel_boot_o && !sel_rsvd_o && !wide_words_o
      && ext_addr_o[EXT_ADDR_W+ATTR_W-1:NARROW_W] == '0);
  endproperty
  a_sc_limit: assert property (p_sc_limit) else $error("compat limit broken"); // R15

  c_cache_hit: cover property (@(posedge clk_i) disable iff (!rst_n)
    req_i && cache_en && addr_i == cache_lo);
  c_ms_on: cover property (@(posedge clk_i) disable iff (!rst_n)
    req_i && memory_switch && !cache_en && addr_i == PRAM_TOP_MS0);
  c_boot: cover property (@(posedge clk_i) disable iff (!rst_n) sel_boot_o);

endmodule // pmm_program_memory_mapper

/* File: pmm_pkg.sv */
package pmm_pkg;
  // address space geometry
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned BANK_WORDS = 256;
  localparam int unsigned BASE_BANKS = 80;
  localparam int unsigned SWITCH_BANKS = 8;
  localparam int unsigned CACHE_BANKS = 4;
  localparam int unsigned EXT_ADDR_W = 18;
  localparam int unsigned ATTR_W = 4;
  localparam int unsigned WORD_W = 24;
  localparam int unsigned NARROW_W = 16;
  // operating-mode and status bit positions
  localparam int unsigned OMR_MS_BIT = 7;
  localparam int unsigned SR_CE_BIT = 19;
  localparam int unsigned SR_SC_BIT = 13;
  // program map boundaries
  localparam logic [23:0] PRAM_TOP_MS0 = 24'h005000;
  localparam logic [23:0] PRAM_TOP_MS1 = 24'h006000;
  localparam logic [23:0] CACHE_LO_MS0 = 24'h004c00;
  localparam logic [23:0] CACHE_LO_MS1 = 24'h005c00;
  localparam logic [23:0] BOOT_LO = 24'hff0000;
  localparam logic [23:0] BOOT_HI = 24'hff00bf;
  localparam logic [23:0] RSVD_LO = 24'hff00c0;
  localparam logic [23:0] RSVD_HI = 24'hffffff;
  localparam logic [23:0] SC_LIMIT = 24'h00ffff;
  localparam logic [7:0] BOOT_WORDS = 8'hc0;
  // decode targets, one-hot
  typedef enum logic [4:0] {
    PMM_TGT_PRAM = 5'h01,
    PMM_TGT_BOOT = 5'h02,
    PMM_TGT_RSVD = 5'h04,
    PMM_TGT_EXT = 5'h08,
    PMM_TGT_NONE = 5'h10
  } pmm_tgt_e;
endpackage

/* File: pmm_core_model.sv */
`timescale 1ns/10ps
// core side: presents fetch addresses and the mode/status words to the mapper
module pmm_core_model (
  input wire logic clk_i,
  output logic req_o,
  output logic [23:0] addr_o,
  output logic [23:0] omr_o,
  output logic [23:0] sr_o
);
  initial begin
    req_o = 1'b0;
    addr_o = 24'h000000;
    omr_o = 24'h000000;
    sr_o = 24'h000000;
  end
  // one fetch request, launched just after an edge and held one cycle
  task automatic issue(input logic r, input logic [23:0] a);
    req_o = r;
    addr_o = a;
  endtask
  // cache off first, then switch, then cache back on, so code never vanishes
  task automatic set_mode(input logic ms, input logic ce, input logic sc, input logic [23:0] r);
    req_o = 1'h0; // no fetches while the map is switching
    sr_o[19] = 1'b0;
    @(posedge clk_i);
    #1;
    omr_o = {r[23:8], ms, r[6:0]};
    @(posedge clk_i);
    #1;
    sr_o = {r[23:20], ce, r[18:14], sc, r[12:0]};
  endtask
endmodule // pmm_core_model

/* File: testbench.sv */
`timescale 1ns/10ps
module testbench;
  logic clk_i, nrst_i, req, sel_pram, sel_boot, sel_rsvd, sel_ext, cache_on, wide;
  logic [23:0] addr, operating_mode_register, sr, pram_words, ext_base, a;
  logic [14:0] pram_addr;
  logic [7:0] boot_addr;
  logic [21:0] ext_addr;
  logic [15:0] rnd;
  logic [3:0] s;
  int fail_count = 0;
  int comparisons = 0;
  logic [23:0] corner [13] = '{24'h0, 24'h4bff, 24'h4c00, 24'h4fff, 24'h5000, 24'h5bff,
    24'h5c00, 24'h5fff, 24'h6000, 24'hff0000, 24'hff00bf, 24'hff00c0, 24'hffffff};
  pmm_core_model pmm_core_model_inst (.clk_i(clk_i), .req_o(req), .addr_o(addr),
    .omr_o(operating_mode_register), .sr_o(sr));
  pmm_program_memory_mapper pmm_program_memory_mapper_inst (.clk_i(clk_i), .nrst_i(nrst_i),
    .operating_mode_register_i(operating_mode_register), .status_register_i(sr), .req_i(req), .addr_i(addr),
    .sel_pram_o(sel_pram), .sel_boot_o(sel_boot), .sel_rsvd_o(sel_rsvd), .sel_ext_o(sel_ext),
    .pram_addr_o(pram_addr), .boot_addr_o(boot_addr), .ext_addr_o(ext_addr),
    .pram_words_o(pram_words), .ext_base_o(ext_base), .cache_active_o(cache_on),
    .wide_words_o(wide));
  // 50 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // next pseudo-random value
  function automatic logic [15:0] lfsr(logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // internal program words for a switch/cache setting
  function automatic logic [23:0] exp_top(logic ms, logic ce);
    return ms ? (ce ? 24'h005c00 : 24'h006000) : (ce ? 24'h004c00 : 24'h005000);
  endfunction
  // expected target {pram, boot, rsvd, ext}
  function automatic logic [3:0] exp_sel(logic [23:0] m, logic ms, logic ce);
    if (m < exp_top(ms, ce)) return 4'h8;
    if (m >= 24'hff0000 && m <= 24'hff00bf) return 4'h4;
    if (m >= 24'hff00c0) return 4'h2;
    return 4'h1;
  endfunction
  task automatic chk_sel(input logic [3:0] got, input logic [3:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("Error t=%0t select got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("Error t=%0t value got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog well past the expected run
  initial begin
    #200000;
    fail_count++;
    end_sim;
  end
  // main sequence: eight switch/cache/compat settings, corners then random fetches
  initial begin
    nrst_i = 1'b0;
    rnd = 16'h85fb;
    repeat (12) @(posedge clk_i);
    #1;
    chk_val(pram_words, 24'h005000);
    chk_sel({sel_pram, sel_boot, sel_rsvd, sel_ext}, 4'h0);
    nrst_i = 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    for (int md = 0; md < 8; md++) begin
      pmm_core_model_inst.set_mode(md[2], md[1], md[0], {rnd, rnd[7:0]});
      pmm_core_model_inst.issue(1'b0, 24'h4c00);
      @(posedge clk_i);
      #1;
      chk_sel({sel_pram, sel_boot, sel_rsvd, sel_ext}, 4'h0);
      chk_val(pram_words, exp_top(md[2], md[1]));
      chk_val(ext_base, md[2] ? 24'h006000 : 24'h005000);
      chk_val({22'h0, cache_on, wide}, {22'h0, md[1], ~md[0]});
      for (int i = 0; i < 33; i++) begin
        a = (i < 13) ? corner[i] : (i[0] ? {9'h000, rnd[14:0]} : {rnd, rnd[15:8]});
        rnd = lfsr(rnd);
        pmm_core_model_inst.issue(1'b1, a);
        @(posedge clk_i);
        #1;
        a = md[0] ? (a & 24'h00ffff) : a;
        s = exp_sel(a, md[2], md[1]);
        chk_sel({sel_pram, sel_boot, sel_rsvd, sel_ext}, s);
        if (s == 4'h1) chk_val({2'h0, ext_addr}, {2'h0, a[21:0]});
        if (s == 4'h4) chk_val({16'h0, boot_addr}, {16'h0, a[7:0]});
        if (s == 4'h8) chk_val({9'h0, pram_addr}, {9'h0, a[14:0]});
      end
      $display("test mode %0d done", md);
    end
    end_sim;
  end
endmodule // testbench
